// [rtl/rpsbl_top.sv]
/*
 * Reset pin-state sequencing, interlocked bus lock, page strobes and flag-pin
 * direction for a two-bus signal processor. Phase clocks are divided from sys_clk.
 * Assumes core-side inputs are synchronous to sys_clk and that the pad ring
 * resolves each _o/_oe pair into the real pin.
 */
// What this block does
// RL1 - reset pin is taken asynchronously; a missed window delays sequencing one cycle
// RL2 - reset source holds reset ten phase-one cycles, releases before a falling edge
// RL3 - both phase clocks are made from input clock rising edges
// RL4 - in reset all data lines float, from a phase-one rising edge
// RL5 - in reset both address buses float, from a phase-three rising edge
// RL6 - in reset strobes, status, lock and read/write go high, page strobes low
// RL7 - in reset the interrupt acknowledge goes high from a phase-one rising edge
// RL8 - reset low floats timer, flag and listed port handshake pins without clock
// RL9 - reset high drives listed port handshake pins high
// RL10 - out of reset ports one and two transmit, four and five receive
// RL11 - interlocked loads drive lock low on a phase-one falling edge
// RL12 - interlocked stores release lock high on a phase-one falling edge
// RL13 - interlocked signal drives lock low then high on phase-one falling edges
// RL14 - access to a new page pulses that bus's page strobe
// RL15 - each flag pin switches between input and output under internal control
// RL16 - flag inputs are sampled on a phase-one falling edge
// RL17 - consecutive reads keep read/write high and the strobe low
// RL18 - the reset pin passes a two-stage synchroniser before sequencing uses it
`timescale 1ns/1ps
`default_nettype none

module rpsbl_top import rpsbl_pkg::*; #(
    parameter int ADDR_W = 24,
    parameter int DATA_W = 32,
    parameter int PAGE_W = 8
) (
    // clock, logic reset and reset pin
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ext_reset_n,
    // phase clocks
    output logic phase_clk_one,
    output logic phase_clk_three,
    // core bus requests, per bus
    input wire logic [NBUS-1:0] bus_access,
    input wire logic [NBUS-1:0] bus_write,
    input wire logic [NBUS-1:0] bus_strobe_sel,
    input wire logic [NBUS-1:0][ADDR_W-1:0] bus_addr,
    input wire logic [NBUS-1:0][DATA_W-1:0] bus_wdata,
    input wire logic [NBUS-1:0][STAT_W-1:0] bus_status,
    output logic [NBUS-1:0][DATA_W-1:0] bus_rdata,
    // interlocked instructions, per bus, one-cycle pulses
    input wire logic [NBUS-1:0] interlocked_float_load,
    input wire logic [NBUS-1:0] interlocked_int_load,
    input wire logic [NBUS-1:0] interlocked_float_store,
    input wire logic [NBUS-1:0] interlocked_int_store,
    input wire logic [NBUS-1:0] interlocked_signal_instr,
    // external bus pins
    output logic [NBUS-1:0][DATA_W-1:0] external_data_bus_o,
    output logic [NBUS-1:0] external_data_bus_oe,
    input wire logic [NBUS-1:0][DATA_W-1:0] external_data_bus_i,
    output logic [NBUS-1:0][ADDR_W-1:0] external_address_bus_o,
    output logic [NBUS-1:0] external_address_bus_oe,
    output logic [NBUS-1:0] memory_strobe_n,
    output logic [NBUS-1:0] bus_read_write,
    output logic [NBUS-1:0][STAT_W-1:0] bus_status_code,
    output logic [NBUS-1:0] bus_lock_n,
    output logic [NBUS-1:0] page_strobe_lo,
    output logic [NBUS-1:0] page_strobe_hi,
    // interrupt acknowledge
    input wire logic interrupt_ack_req,
    output logic interrupt_ack_out,
    // flag pins
    input wire logic [NFLAG-1:0] irq_flag_dir_out,
    input wire logic [NFLAG-1:0] irq_flag_out_val,
    output logic [NFLAG-1:0] irq_flag_sampled,
    output logic [NFLAG-1:0] irq_flag_pin_o,
    output logic [NFLAG-1:0] irq_flag_pin_oe,
    input wire logic [NFLAG-1:0] irq_flag_pin_i,
    // timer clock pins, index 0 is timer_clock_pin_zero, index 1 timer_clock_pin_one
    input wire logic [NTIMER-1:0] timer_clock_core_o,
    input wire logic [NTIMER-1:0] timer_clock_core_oe,
    output logic [NTIMER-1:0] timer_clock_pin_o,
    output logic [NTIMER-1:0] timer_clock_pin_oe,
    // port handshake from the transfer logic
    input wire logic [NPORT-1:0] cp_req_o,
    input wire logic [NPORT-1:0] cp_req_oe,
    input wire logic [NPORT-1:0] cp_ack_o,
    input wire logic [NPORT-1:0] cp_ack_oe,
    input wire logic [NPORT-1:0] cp_strb_o,
    input wire logic [NPORT-1:0] cp_strb_oe,
    input wire logic [NPORT-1:0] cp_rdy_o,
    input wire logic [NPORT-1:0] cp_rdy_oe,
    input wire logic [NPORT-1:0][BYTE_W-1:0] cp_data_o,
    input wire logic [NPORT-1:0] cp_data_oe,
    // port direction control
    input wire logic port_dir_load,
    input wire logic [NPORT-1:0] port_dir_req,
    output logic [NPORT-1:0] port_direction,
    // port pins
    output logic [NPORT-1:0] port_token_request_o,
    output logic [NPORT-1:0] port_token_request_oe,
    output logic [NPORT-1:0] port_token_acknowledge_o,
    output logic [NPORT-1:0] port_token_acknowledge_oe,
    output logic [NPORT-1:0] port_byte_strobe_o,
    output logic [NPORT-1:0] port_byte_strobe_oe,
    output logic [NPORT-1:0] port_byte_ready_o,
    output logic [NPORT-1:0] port_byte_ready_oe,
    output logic [NPORT-1:0][BYTE_W-1:0] port_data_lines_o,
    output logic [NPORT-1:0] port_data_lines_oe
);

    logic reset_sync_n;
    logic h1_reg;
    logic h3_reg;
    logic h1_fall;
    logic h1_rise;
    logic rst_h1_reg;
    logic rst_h3_reg;
    logic [NBUS-1:0] data_drive_reg;
    logic [NBUS-1:0][PAGE_W-1:0] last_page_reg;
    logic [NBUS-1:0] load_pend_reg;
    logic [NBUS-1:0] store_pend_reg;
    logic [NBUS-1:0] sig_pend_reg;
    logic [NFLAG-1:0] flag_dir_reg;
    logic [NFLAG-1:0] flag_val_reg;
    rpsbl_lock_type lock_state_reg [NBUS];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    function automatic logic [PAGE_W-1:0] page_of(input logic [ADDR_W-1:0] addr);
        page_of = addr[ADDR_W-1 -: PAGE_W];
    endfunction : page_of

    // raw reset floats at once; after release the masked pins drive until sequencing ends
    function automatic logic [NPORT-1:0] async_oe(input logic pin_n, input logic seq_rst,
                                                  input logic [NPORT-1:0] mask, input logic [NPORT-1:0] core_oe);
        async_oe = (seq_rst ? mask : core_oe) & {NPORT{pin_n}};
    endfunction : async_oe

    rpsbl_sync2 u_reset_sync ( // [RL18] [RL1]
        .sys_clk(sys_clk),
        .srst(srst),
        .async_in_n(ext_reset_n),
        .sync_out_n(reset_sync_n)
    );

    // phase clocks: each edge follows an input clock rising edge
    always_ff @(posedge sys_clk) begin // [RL3]
        if (srst) begin
            h1_reg <= 1'b0;
            h3_reg <= 1'b1;
        end else begin
            h1_reg <= ~h1_reg;
            h3_reg <= h1_reg;
        end
    end
    assign h1_fall = h1_reg;
    assign h1_rise = ~h1_reg;
    assign phase_clk_one = h1_reg;
    assign phase_clk_three = h3_reg;

    // reset sequence: data side from phase-one rise, address/control from phase-three rise
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rst_h1_reg <= 1'b1;
            rst_h3_reg <= 1'b1;
        end else if (h1_rise && !reset_sync_n) begin
            rst_h1_reg <= 1'b1; // [RL4] [RL7]
        end else if (h1_fall) begin
            rst_h3_reg <= ~reset_sync_n; // [RL5] [RL6]
            if (reset_sync_n) begin
                rst_h1_reg <= 1'b0; // [RL2]
            end
        end
    end

    // port directions, loaded while reset is sequenced
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            port_direction <= PORT_DIR_AT_RESET;
        end else if (rst_h1_reg && h1_rise) begin
            port_direction <= PORT_DIR_AT_RESET; // [RL10]
        end else if (port_dir_load && !rst_h1_reg) begin
            port_direction <= port_dir_req;
        end
    end

    // interrupt acknowledge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            interrupt_ack_out <= 1'b1;
        end else if (h1_rise) begin
            interrupt_ack_out <= rst_h1_reg | ~reset_sync_n | ~interrupt_ack_req; // [RL7]
        end
    end

    // flag pins: direction and drive value move on phase-one falling edges
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flag_dir_reg <= '0;
            flag_val_reg <= '0;
            irq_flag_sampled <= '0;
        end else if (h1_fall) begin
            flag_dir_reg <= rst_h3_reg ? '0 : irq_flag_dir_out; // [RL15]
            flag_val_reg <= irq_flag_out_val;
            irq_flag_sampled <= irq_flag_pin_i & ~flag_dir_reg; // [RL16]
        end
    end
    assign irq_flag_pin_o = flag_val_reg;
    assign irq_flag_pin_oe = flag_dir_reg & {NFLAG{ext_reset_n & ~rst_h3_reg}}; // [RL8]

    // timer and port handshake pins float straight from the raw reset pin
    assign timer_clock_pin_o = timer_clock_core_o;
    assign timer_clock_pin_oe = timer_clock_core_oe & {NTIMER{ext_reset_n & ~rst_h3_reg}}; // [RL8]
    assign port_token_request_o = rst_h3_reg ? REQ_RDY_DRIVE_MASK : cp_req_o; // [RL9]
    assign port_byte_ready_o = rst_h3_reg ? REQ_RDY_DRIVE_MASK : cp_rdy_o;
    assign port_token_acknowledge_o = rst_h3_reg ? ACK_STRB_DRIVE_MASK : cp_ack_o;
    assign port_byte_strobe_o = rst_h3_reg ? ACK_STRB_DRIVE_MASK : cp_strb_o;
    assign port_token_request_oe = async_oe(ext_reset_n, rst_h3_reg, REQ_RDY_DRIVE_MASK, cp_req_oe); // [RL8] [RL9]
    assign port_byte_ready_oe = async_oe(ext_reset_n, rst_h3_reg, REQ_RDY_DRIVE_MASK, cp_rdy_oe); // [RL8] [RL9]
    assign port_token_acknowledge_oe = async_oe(ext_reset_n, rst_h3_reg, ACK_STRB_DRIVE_MASK, cp_ack_oe); // [RL8]
    assign port_byte_strobe_oe = async_oe(ext_reset_n, rst_h3_reg, ACK_STRB_DRIVE_MASK, cp_strb_oe); // [RL8]

    // port data lines
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            port_data_lines_o <= '0;
            port_data_lines_oe <= '0;
        end else begin
            port_data_lines_o <= cp_data_o;
            port_data_lines_oe <= (rst_h1_reg || (h1_rise && !reset_sync_n)) ? NO_DRIVE_MASK : cp_data_oe; // [RL4]
        end
    end

    for (genvar b = 0; b < NBUS; b++) begin : g_bus
        // lock requests wait for the next phase-one falling edge; a new request beats the clear
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                load_pend_reg[b] <= 1'b0;
                store_pend_reg[b] <= 1'b0;
                sig_pend_reg[b] <= 1'b0;
            end else begin
                load_pend_reg[b] <= interlocked_float_load[b] | interlocked_int_load[b] | (load_pend_reg[b] & ~h1_fall);
                store_pend_reg[b] <= interlocked_float_store[b] | interlocked_int_store[b]
                                     | (store_pend_reg[b] & ~h1_fall);
                sig_pend_reg[b] <= interlocked_signal_instr[b] | (sig_pend_reg[b] & ~h1_fall);
            end
        end

        always_ff @(posedge sys_clk) begin
            if (srst) begin
                lock_state_reg[b] <= LOCK_OPEN;
                bus_lock_n[b] <= 1'b1;
            end else if (h1_fall) begin
                if (rst_h3_reg) begin
                    lock_state_reg[b] <= LOCK_OPEN;
                    bus_lock_n[b] <= 1'b1; // [RL6]
                end else begin
                    case (lock_state_reg[b])
                        LOCK_OPEN: begin
                            if (sig_pend_reg[b]) begin
                                lock_state_reg[b] <= LOCK_SIGNAL;
                                bus_lock_n[b] <= 1'b0; // [RL13]
                            end else if (load_pend_reg[b]) begin
                                lock_state_reg[b] <= LOCK_HELD;
                                bus_lock_n[b] <= 1'b0; // [RL11]
                            end
                        end
                        LOCK_HELD: begin
                            if (store_pend_reg[b]) begin
                                lock_state_reg[b] <= LOCK_OPEN;
                                bus_lock_n[b] <= 1'b1; // [RL12]
                            end
                        end
                        LOCK_SIGNAL: begin
                            lock_state_reg[b] <= LOCK_OPEN;
                            bus_lock_n[b] <= 1'b1; // [RL13]
                        end
                        default: begin
                            lock_state_reg[b] <= LOCK_OPEN;
                            bus_lock_n[b] <= 1'b1;
                        end
                    endcase
                end
            end
        end

        // strobe, read/write, status, address and page strobes change on phase-one falls
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                memory_strobe_n[b] <= 1'b1;
                bus_read_write[b] <= 1'b1;
                bus_status_code[b] <= STATUS_PARKED;
                external_address_bus_o[b] <= '0;
                last_page_reg[b] <= '0;
                page_strobe_lo[b] <= 1'b0;
                page_strobe_hi[b] <= 1'b0;
                bus_rdata[b] <= '0;
            end else if (h1_fall) begin
                bus_rdata[b] <= external_data_bus_i[b];
                if (rst_h3_reg) begin
                    memory_strobe_n[b] <= 1'b1; // [RL6]
                    bus_read_write[b] <= 1'b1;
                    bus_status_code[b] <= STATUS_PARKED;
                    page_strobe_lo[b] <= 1'b0;
                    page_strobe_hi[b] <= 1'b0;
                end else begin
                    memory_strobe_n[b] <= ~bus_access[b]; // [RL17]
                    bus_read_write[b] <= ~(bus_access[b] & bus_write[b]); // [RL17]
                    bus_status_code[b] <= bus_access[b] ? bus_status[b] : STATUS_PARKED;
                    external_address_bus_o[b] <= bus_addr[b];
                    page_strobe_lo[b] <= bus_access[b] && !bus_strobe_sel[b]
                                         && page_of(bus_addr[b]) != last_page_reg[b]; // [RL14]
                    page_strobe_hi[b] <= bus_access[b] && bus_strobe_sel[b]
                                         && page_of(bus_addr[b]) != last_page_reg[b]; // [RL14]
                    if (bus_access[b]) begin
                        last_page_reg[b] <= page_of(bus_addr[b]);
                    end
                end
            end
        end

        // write data is launched with the phase-one rise, floated in reset
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                external_data_bus_o[b] <= '0;
                data_drive_reg[b] <= 1'b0;
            end else if (h1_rise) begin
                external_data_bus_o[b] <= bus_wdata[b];
                data_drive_reg[b] <= reset_sync_n & ~rst_h3_reg & bus_access[b] & bus_write[b]; // [RL4]
            end
        end
        assign external_data_bus_oe[b] = data_drive_reg[b] & ~rst_h1_reg;
        assign external_address_bus_oe[b] = ~rst_h3_reg; // [RL5]
    end

    localparam int SYNC_MAX = 5;

    // the first edge out of reset still sees the reset values in $past
    phase_split_a: assert property (!$past(srst) |-> h1_reg != $past(h1_reg) && h3_reg == $past(h1_reg)) // [RL3]
        else $error("phase clocks not derived from input clock edges");
    reset_seen_a: assert property ($fell(ext_reset_n) ##1 !ext_reset_n[*3] |-> ##[0:SYNC_MAX] rst_h1_reg) // [RL18]
        else $error("reset pin not seen through synchroniser");
    data_float_a: assert property (rst_h1_reg |-> external_data_bus_oe == '0 && port_data_lines_oe == '0) // [RL4]
        else $error("data lines driven during reset");
    addr_float_a: assert property (rst_h3_reg |-> external_address_bus_oe == '0) // [RL5]
        else $error("address bus driven during reset");
    ctl_park_a: assert property ($rose(rst_h3_reg) |=> ##1 memory_strobe_n == '1 && bus_read_write == '1
                                 && bus_lock_n == '1 && page_strobe_lo == '0 && page_strobe_hi == '0) // [RL6]
        else $error("bus control not parked in reset");
    interrupt_ack_out_park_a: assert property (rst_h1_reg && h1_rise |=> interrupt_ack_out) // [RL7]
        else $error("acknowledge not high in reset");
    async_float_a: assert property (!ext_reset_n |-> timer_clock_pin_oe == '0 && irq_flag_pin_oe == '0
                                    && port_token_request_oe == '0 && port_byte_strobe_oe == '0) // [RL8]
        else $error("pins not floated while reset pin low");
    drive_high_a: assert property (ext_reset_n && rst_h3_reg |-> port_token_request_oe == REQ_RDY_DRIVE_MASK
                                   && port_byte_strobe_oe == ACK_STRB_DRIVE_MASK && port_byte_ready_o[3]) // [RL9]
        else $error("handshake pins not driven high after reset");
    dir_init_a: assert property ($fell(rst_h1_reg) |-> port_direction == PORT_DIR_AT_RESET) // [RL10]
        else $error("port directions wrong out of reset");
    lock_load_a: assert property (h1_fall && !rst_h3_reg && lock_state_reg[0] == LOCK_OPEN && load_pend_reg[0]
                                  && !sig_pend_reg[0] |=> !bus_lock_n[0] && !h1_fall) // [RL11]
        else $error("lock not asserted for interlocked load");
    lock_store_a: assert property (h1_fall && !rst_h3_reg && lock_state_reg[0] == LOCK_HELD && store_pend_reg[0]
                                   |=> bus_lock_n[0]) // [RL12]
        else $error("lock not released for interlocked store");
    lock_signal_a: assert property (h1_fall && !rst_h3_reg && lock_state_reg[0] == LOCK_OPEN && sig_pend_reg[0]
                                    |=> !bus_lock_n[0] ##2 bus_lock_n[0]) // [RL13]
        else $error("signal instruction lock pulse wrong");
    page_pulse_a: assert property (h1_fall && !rst_h3_reg && bus_access[0] && !bus_strobe_sel[0]
                                   && page_of(bus_addr[0]) != last_page_reg[0] |=> page_strobe_lo[0]) // [RL14]
        else $error("page strobe missing on page change");
    read_hold_a: assert property (h1_fall && !rst_h3_reg && bus_access[0] && !bus_write[0]
                                  |=> !memory_strobe_n[0] && bus_read_write[0]) // [RL17]
        else $error("read cycle strobe or direction wrong");
    flag_out_a: assert property (flag_dir_reg[0] && ext_reset_n && !rst_h3_reg |-> irq_flag_pin_oe[0]) // [RL15]
        else $error("flag output not driven");
    flag_sample_a: assert property (h1_fall && !flag_dir_reg[1]
                                    |=> irq_flag_sampled[1] == $past(irq_flag_pin_i[1])) // [RL16]
        else $error("flag input not sampled on phase-one fall");

endmodule : rpsbl_top
`default_nettype wire

// [rtl/rpsbl_pkg.sv]
/*
 * Shared constants and types for the reset pin-state and bus-lock block.
 * Assumes two external buses, four flag pins and four communication ports
 * (ports 1, 2, 4, 5 mapped to vector indices 0, 1, 2, 3).
 */
package rpsbl_pkg;

    localparam int NBUS = 2;
    localparam int NPORT = 4;
    localparam int NFLAG = 4;
    localparam int NTIMER = 2;
    localparam int STAT_W = 4;
    localparam int BYTE_W = 8;

    // ports 1 and 2 own the transmit side after reset, 4 and 5 receive
    localparam logic [3:0] PORT_DIR_AT_RESET = 4'h3;
    // pins driven high once the reset input returns high
    localparam logic [3:0] REQ_RDY_DRIVE_MASK = 4'hC;
    localparam logic [3:0] ACK_STRB_DRIVE_MASK = 4'h3;
    localparam logic [3:0] NO_DRIVE_MASK = 4'h0;
    localparam logic [STAT_W-1:0] STATUS_PARKED = 4'hF;

    // least hold of the reset input, in phase-one cycles, kept by the source
    localparam int RESET_HOLD_H1_CYCLES = 10;

    typedef enum logic [2:0] {
        LOCK_OPEN = 3'h1,
        LOCK_HELD = 3'h2,
        LOCK_SIGNAL = 3'h4
    } rpsbl_lock_type;

endpackage : rpsbl_pkg

// [rtl/rpsbl_sync2.sv]
/*
 * Two-stage synchroniser for the active-low reset pin.
 * Assumes the pin may change at any time relative to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module rpsbl_sync2 (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // raw and synchronised level
    input wire logic async_in_n,
    output logic sync_out_n
);

    logic stage_one_reg;

    // first stage feeds only the second; both start in the asserted state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stage_one_reg <= 1'b0;
            sync_out_n <= 1'b0;
        end else begin
            stage_one_reg <= async_in_n;
            sync_out_n <= stage_one_reg;
        end
    end

endmodule : rpsbl_sync2
`default_nettype wire

// [bench/rpsbl_peer.sv]
/* far-side model: flag sources and memory data lines
   assumes phase_clk_one comes from the block under test */
`timescale 1ns/1ps
`default_nettype none
module rpsbl_peer import rpsbl_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic phase_clk_one,
    // flag source and memory data
    input wire logic [NFLAG-1:0] flag_val,
    output logic [NFLAG-1:0] flag_pin,
    output logic [NBUS-1:0][31:0] mem_data
);
    // flags move just after a phase-one fall, so they stay put around the next one
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flag_pin <= '0;
        end else if (phase_clk_one) begin
            flag_pin <= flag_val;
        end
    end
    // undriven data lines never hold a value
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mem_data <= {2{32'h5A5A5A5A}};
        end else begin
            mem_data <= ~mem_data;
        end
    end
endmodule : rpsbl_peer
`default_nettype wire

// [bench/tb_rpsbl_top.sv]
/* bench for rpsbl_top: reset pin states, lock, page strobe, flag pins
   assumes rpsbl_peer as the far side of flag and data pins */
`timescale 1ns/1ps
`default_nettype none
module tb_rpsbl_top import rpsbl_pkg::*; ;
    logic sys_clk = 0, srst = 1, ext_reset_n = 0, phase_clk_one, phase_clk_three, interrupt_ack_req = 0;
    logic interrupt_ack_out, port_dir_load = 0;
    logic [9:0] ilk = '0;
    wire logic [NBUS-1:0] interlocked_int_load, interlocked_float_load, interlocked_int_store;
    wire logic [NBUS-1:0] interlocked_float_store, interlocked_signal_instr;
    logic [NBUS-1:0] bus_access = '0, bus_write = '0, bus_strobe_sel = '0, bus_lock_n, memory_strobe_n;
    logic [NBUS-1:0] bus_read_write, page_strobe_lo, page_strobe_hi, external_data_bus_oe, external_address_bus_oe;
    logic [NBUS-1:0][23:0] bus_addr = '0, external_address_bus_o;
    logic [NBUS-1:0][31:0] bus_wdata = '0, bus_rdata, external_data_bus_o, external_data_bus_i;
    logic [NBUS-1:0][3:0] bus_status = '0, bus_status_code;
    logic [3:0] irq_flag_dir_out = '1, irq_flag_out_val = '0, flag_val = '0, irq_flag_sampled, irq_flag_pin_o;
    logic [3:0] irq_flag_pin_oe, irq_flag_pin_i, port_dir_req = '0, port_direction;
    logic [1:0] timer_clock_core_o = '1, timer_clock_core_oe = '1, timer_clock_pin_o, timer_clock_pin_oe;
    logic [3:0] cp_req_o = '1, cp_req_oe = '1, cp_ack_o = '1, cp_ack_oe = '1, cp_strb_o = '1, cp_strb_oe = '1;
    logic [3:0] cp_rdy_o = '1, cp_rdy_oe = '1, cp_data_oe = '1;
    logic [3:0][7:0] cp_data_o = '0, port_data_lines_o;
    logic [3:0] port_token_request_o, port_token_request_oe, port_token_acknowledge_o, port_token_acknowledge_oe;
    logic [3:0] port_byte_strobe_o, port_byte_strobe_oe, port_byte_ready_o, port_byte_ready_oe, port_data_lines_oe;
    int n_errors = 0, samples_checked = 0;
    assign {interlocked_signal_instr, interlocked_float_store, interlocked_int_store} = ilk[9:4];
    assign {interlocked_float_load, interlocked_int_load} = ilk[3:0];
    rpsbl_top dut_u (.*);
    rpsbl_peer peer_u (.sys_clk, .srst, .phase_clk_one, .flag_val, .flag_pin(irq_flag_pin_i),
        .mem_data(external_data_bus_i));
    always #2 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    task automatic t_reset();
        @(posedge sys_clk) {port_dir_load, port_dir_req} <= 5'h1C;
        @(posedge sys_clk) begin
            port_dir_load <= 0;
            ext_reset_n <= 0;
        end
        repeat (24) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("data_oe", external_data_bus_oe, 0);
        chk("addr_oe", external_address_bus_oe, 0);
        chk("ctl", {memory_strobe_n, bus_read_write, bus_lock_n, bus_status_code}, 14'h3FFF);
        chk("page", {page_strobe_lo, page_strobe_hi}, 0);
        chk("interrupt_ack_out", interrupt_ack_out, 1);
        chk("float", {timer_clock_pin_oe, irq_flag_pin_oe, port_token_request_oe[1:0], port_byte_ready_oe[1:0],
            port_token_acknowledge_oe[3:2], port_byte_strobe_oe[3:2]}, 0);
        @(posedge sys_clk) ext_reset_n <= 1;
        repeat (2) @(negedge sys_clk);
        chk("hs", {port_token_request_o[3:2], port_token_request_oe[3:2], port_byte_ready_o[3:2],
            port_byte_ready_oe[3:2], port_token_acknowledge_o[1:0], port_token_acknowledge_oe[1:0],
            port_byte_strobe_o[1:0], port_byte_strobe_oe[1:0]}, 16'hFFFF);
        repeat (8) @(negedge sys_clk);
        chk("dir", port_direction, 4'h3);
    endtask : t_reset
    task automatic fire(input int k, input logic [1:0] b);
        @(posedge sys_clk) ilk <= 10'(b) << (2 * k);
        @(posedge sys_clk) ilk <= '0;
    endtask : fire
    task automatic lock_is(input logic [1:0] e);
        @(negedge sys_clk);
        repeat (8) if (bus_lock_n !== e) @(negedge sys_clk);
        chk("lock", bus_lock_n, e);
    endtask : lock_is
    task automatic t_lock();
        int n;
        fire(0, 2'b01);
        lock_is(2'b10);
        fire(1, 2'b10);
        lock_is(2'b00);
        fire(2, 2'b01);
        lock_is(2'b01);
        fire(3, 2'b10);
        lock_is(2'b11);
        fire(4, 2'b01);
        lock_is(2'b10);
        n = 0;
        while (bus_lock_n[0] === 1'b0 && n < 9) begin
            n++;
            @(negedge sys_clk);
        end
        chk("sig_low", n, 2);
    endtask : t_lock
    task automatic t_page();
        logic [1:0] pg;
        pg = '0;
        @(posedge sys_clk);
        bus_addr[0] <= 24'h010004;
        bus_access <= 2'b01;
        repeat (6) @(negedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk) if (i == 2) bus_addr[0] <= 24'h020000;
            @(negedge sys_clk);
            pg |= {page_strobe_hi[0], page_strobe_lo[0]};
            chk("rd_hold", {memory_strobe_n[0], bus_read_write[0]}, 2'b01);
        end
        chk("page_pulse", pg, 2'b01);
        chk("rdata", bus_rdata[0], 32'hA5A5A5A5);
        chk("addr", {external_address_bus_oe, external_address_bus_o[0]}, {2'b11, 24'h020000});
        @(posedge sys_clk) {bus_write[0], bus_wdata[0], interrupt_ack_req} <= {1'b1, 32'hC0DE5A11, 1'b1};
        repeat (4) @(negedge sys_clk);
        chk("wr_data", external_data_bus_o[0], 32'hC0DE5A11);
        chk("wr_ctl", {external_data_bus_oe, bus_read_write[0], interrupt_ack_out}, 4'h4);
        @(posedge sys_clk) {bus_access, bus_write, interrupt_ack_req} <= '0;
    endtask : t_page
    task automatic t_flag();
        @(posedge sys_clk);
        irq_flag_dir_out <= '0;
        flag_val <= 4'hA;
        repeat (8) @(negedge sys_clk);
        chk("f_in", {irq_flag_pin_oe, irq_flag_sampled}, 8'h0A);
        @(posedge sys_clk);
        irq_flag_dir_out <= 4'h6;
        irq_flag_out_val <= 4'h5;
        repeat (6) @(negedge sys_clk);
        chk("f_out", {irq_flag_pin_oe, irq_flag_pin_o & 4'h6}, 8'h64);
    endtask : t_flag
    initial begin
        repeat (2) @(posedge sys_clk);
        srst <= 0;
        t_reset();
        t_lock();
        t_page();
        t_flag();
        t_reset();
        test_done();
    end
    initial begin
        repeat (2000) @(posedge sys_clk);
        n_errors++;
        test_done();
    end
endmodule : tb_rpsbl_top
`default_nettype wire
